/* File: design/setup_filter_pkg.sv */
`default_nettype none
package setup_filter_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0]  MODE_REG_OFS      = 8'h00;
  localparam logic [7:0]  STATUS_REG_OFS    = 8'h04;
  localparam int          BUS_ADDR_W        = 8;
  // controller_mode_reg address_filter_mode field
  localparam int          MODE_PROMISC_BIT  = 0;
  localparam int          MODE_ALLMULTI_BIT = 1;
  localparam logic [1:0]  MODE_RESET        = 2'h0;
  // controller_status_reg fields
  localparam int          STAT_TI_BIT       = 0;
  localparam int          STAT_BUSY_BIT     = 1;
  localparam int          STAT_HASH_BIT     = 2;
  localparam int          STAT_INV_BIT      = 3;
  localparam int          STAT_FAULT_BIT    = 4;
  // transmit descriptor word 1 (tx_desc_word1)
  localparam int          TD1_CA_BIT        = 24;
  localparam int          TD1_VT_BIT        = 23;
  localparam int          TD1_VA_BIT        = 30;
  // setup descriptor fields
  localparam int          SD0_OWN_BIT       = 31;
  localparam int          SD0_ES_BIT        = 15;
  localparam int          SD0_SE_BIT        = 13;
  localparam int          SD1_IC_BIT        = 24;
  localparam int          SD1_HP_BIT        = 25;
  localparam int          SD1_IF_BIT        = 26;
  localparam int          SD1_DT_HI         = 29;
  localparam int          SD1_DT_LO         = 28;
  localparam logic [1:0]  DT_SETUP          = 2'h2;
  localparam int          SD2_BS_HI         = 30;
  localparam int          SD2_BS_LO         = 16;
  localparam logic [14:0] SETUP_BYTES       = 15'h0080;
  // setup buffer layout, in 32-bit words
  localparam int          SETUP_WORDS       = 32;
  localparam int          PERFECT_ENTRIES   = 16;
  localparam int          HASH_WORDS        = 16;
  localparam int          PHYS_WORD_LO      = 16;
  localparam int          PHYS_WORD_HI      = 17;
  localparam logic [31:0] TABLE_RESET       = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_FETCH = 2'b11,
    ST_DONE  = 2'b10
  } setup_state_t;

  typedef enum logic [1:0] {
    ADDR_BUFFER   = 2'h0,
    ADDR_SV_PTE   = 2'h1,
    ADDR_PA_PTE   = 2'h2,
    ADDR_NEXT_DSC = 2'h3
  } addr_kind_t;

  typedef enum logic [2:0] {
    CAUSE_NORMAL    = 3'h0,
    CAUSE_UNDERFLOW = 3'h1,
    CAUSE_EXCESS    = 3'h2,
    CAUSE_WATCHDOG  = 3'h3,
    CAUSE_LOOPBACK  = 3'h4
  } tx_cause_t;

  // validity mask order: {lo, nc, lc, ec, hf, cc, summary}
  localparam logic [6:0] VALID_ALL       = 7'h7F;
  localparam logic [6:0] VALID_UNDERFLOW = 7'h1F & 7'h7F & 7'b0011011;
  localparam logic [6:0] VALID_EXCESS    = 7'b1111101;
  localparam logic [6:0] VALID_WATCHDOG  = 7'b0100011;
endpackage
`default_nettype wire

/* File: design/setup_frame_filter_loader.sv */
// Contract
// - va set: address word is PTE address
// - va clear: address word is buffer address
// - chain flag: address is next descriptor
// - buffers may start at any byte
// - underflow/loopback/excess collisions validity masks
// - watchdog: only nc, cc, summary valid
// - setup frame never transmitted nor looped
// - receiver detached while setup is processed
// - perfect list or hash table plus address
// - table zero; only zero address accepted
// - needs tx running; rx state untouched
// - wait for prior frames and reception
// - wrong size sets bits 13 and 15
// - ownership bit cleared on hand-back
// - completion flag sets transmit interrupt bit
// - bit 25 selects hash or exact mode
// - inverse: accept non-matching, reject matching
// - inverse only exact mode, no promisc/allmulti
// - sixteen 48-bit exact addresses compared
// - crc top nine bits index hash table
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module setup_frame_filter_loader
  import setup_filter_pkg::*;
(
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  // avalon-mm register slave
  input  wire logic [setup_filter_pkg::BUS_ADDR_W-1:0] address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [31:0]                         writedata,
  output logic      [31:0]                         readdata,
  output logic                                     waitrequest,
  // transmit descriptor address resolution
  input  wire logic                                txd_valid,
  input  wire logic [31:0]                         tx_desc_word1,
  input  wire logic [31:0]                         tx_buffer_address_word,
  output logic                                     txd_out_valid_ff,
  output setup_filter_pkg::addr_kind_t             txd_kind_ff,
  output logic      [31:0]                         txd_addr_ff,
  // completion status validity
  input  wire setup_filter_pkg::tx_cause_t         tx_cause,
  output logic      [6:0]                          status_valid_ff,
  // transmit and receive engine state
  input  wire logic                                tx_running,
  input  wire logic                                tx_prior_pending,
  input  wire logic                                rx_frame_busy,
  // setup descriptor in
  input  wire logic                                sd_valid,
  output logic                                     sd_ready,
  input  wire logic [31:0]                         setup_desc_word0,
  input  wire logic [31:0]                         setup_desc_word1,
  input  wire logic [31:0]                         setup_desc_word2,
  // setup buffer words in
  input  wire logic                                sbuf_valid,
  output logic                                     sbuf_ready,
  input  wire logic [31:0]                         sbuf_data,
  // descriptor hand-back
  output logic                                     wb_valid_ff,
  output logic      [31:0]                         wb_word0_ff,
  // receive filter
  output logic                                     rx_detach_ff,
  input  wire logic                                rx_dest_valid,
  input  wire logic [47:0]                         rx_dest,
  output logic                                     rx_result_valid_ff,
  output logic                                     rx_accept_ff
);

  ////////////////////////////////////////////////////////////////////////
  setup_state_t      state_ff;
  setup_state_t      nxt_state;
  logic [31:0]       tbl_ff [SETUP_WORDS];
  logic [4:0]        wcnt_ff;
  logic [31:0]       sd0_ff;
  logic [31:0]       sd1_ff;
  logic [31:0]       sd2_ff;
  logic [1:0]        mode_ff;
  logic              ti_ff;
  logic              hash_ff;
  logic              inv_ff;
  logic              fault_ff;
  logic              ack_ff;
  logic              size_ok;
  logic              prereq_ok;
  logic              last_word;
  logic              bus_req;
  logic              bus_take;
  logic              ti_clr;
  logic [PERFECT_ENTRIES-1:0] hit;
  logic [8:0]        hidx;
  logic              multicast;
  logic              phys_hit;
  logic              inv_eff;
  logic              nxt_accept;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second cycle
  assign bus_req     = read | write;
  assign waitrequest = bus_req & ~ack_ff;
  assign bus_take    = bus_req & ack_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_ff <= MODE_RESET;
    end else if (bus_take && write && address == MODE_REG_OFS) begin
      mode_ff <= writedata[1:0];
    end
  end

  // loaded in the wait cycle so it stands at the edge where waitrequest drops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_ff) begin
      case (address)
        MODE_REG_OFS:   readdata <= {30'h0000_0000, mode_ff};
        STATUS_REG_OFS: readdata <= {27'h000_0000, fault_ff, inv_ff,
                                     hash_ff, rx_detach_ff, ti_ff};
        default:        readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign ti_clr = bus_take & write & (address == STATUS_REG_OFS)
                & writedata[STAT_TI_BIT];

  // interrupt flag set; set beats write-one-clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ti_ff <= 1'b0;
    end else if (state_ff == ST_DONE && sd1_ff[SD1_IC_BIT]) begin
      ti_ff <= 1'b1;
    end else if (ti_clr) begin
      ti_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address word interpretation; chain wins over virtual addressing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txd_out_valid_ff <= 1'b0;
      txd_kind_ff      <= ADDR_BUFFER;
      txd_addr_ff      <= 32'h0000_0000;
    end else begin
      txd_out_valid_ff <= txd_valid;
      txd_addr_ff      <= tx_buffer_address_word;
      if (tx_desc_word1[TD1_CA_BIT]) begin
        txd_kind_ff <= ADDR_NEXT_DSC;
      end else if (tx_desc_word1[TD1_VA_BIT]) begin
        txd_kind_ff <= tx_desc_word1[TD1_VT_BIT] ? ADDR_SV_PTE
                                                 : ADDR_PA_PTE;
      end else begin
        txd_kind_ff <= ADDR_BUFFER;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_valid_ff <= VALID_ALL;
    end else begin
      case (tx_cause)
        CAUSE_UNDERFLOW: status_valid_ff <= VALID_UNDERFLOW;
        CAUSE_LOOPBACK:  status_valid_ff <= VALID_UNDERFLOW;
        CAUSE_EXCESS:    status_valid_ff <= VALID_EXCESS;
        CAUSE_WATCHDOG:  status_valid_ff <= VALID_WATCHDOG;
        default:         status_valid_ff <= VALID_ALL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // setup frame sequencer
  // size checked before any table write
  assign size_ok   = sd2_ff[SD2_BS_HI:SD2_BS_LO] == SETUP_BYTES;
  // tx must run, earlier work must drain
  assign prereq_ok = tx_running & ~tx_prior_pending & ~rx_frame_busy;
  assign last_word = sbuf_valid & (wcnt_ff == 5'(SETUP_WORDS - 1));
  assign sd_ready  = (state_ff == ST_IDLE);
  assign sbuf_ready = (state_ff == ST_FETCH);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // only type-2 descriptors are taken as setup
      ST_IDLE:  if (sd_valid && setup_desc_word1[SD1_DT_HI:SD1_DT_LO]
                                == DT_SETUP) begin
                  nxt_state = ST_WAIT;
                end
      ST_WAIT:  if (prereq_ok) begin
                  nxt_state = size_ok ? ST_FETCH : ST_DONE;
                end
      ST_FETCH: if (last_word) begin
                  nxt_state = ST_DONE;
                end
      ST_DONE:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sd0_ff <= 32'h0000_0000;
      sd1_ff <= 32'h0000_0000;
      sd2_ff <= 32'h0000_0000;
    end else if (sd_valid && sd_ready) begin
      sd0_ff <= setup_desc_word0;
      sd1_ff <= setup_desc_word1;
      sd2_ff <= setup_desc_word2;
    end
  end

  // receiver off the wire from acceptance to hand-back
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_detach_ff <= 1'b0;
    end else begin
      rx_detach_ff <= (nxt_state != ST_IDLE);
    end
  end

  // mode latched when a good frame starts loading
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hash_ff <= 1'b0;
      inv_ff  <= 1'b0;
    end else if (state_ff == ST_WAIT && prereq_ok && size_ok) begin
      hash_ff <= sd1_ff[SD1_HP_BIT];
      inv_ff  <= sd1_ff[SD1_IF_BIT];
    end
  end

  // setup words go only into the table, never to tx or rx
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wcnt_ff <= 5'h00;
    end else if (state_ff != ST_FETCH) begin
      wcnt_ff <= 5'h00;
    end else if (sbuf_valid) begin
      wcnt_ff <= wcnt_ff + 5'h01;
    end
  end

  // whole buffer stored; zero after reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < SETUP_WORDS; i++) begin
        tbl_ff[i] <= TABLE_RESET;
      end
    end else if (sbuf_valid && sbuf_ready) begin
      tbl_ff[wcnt_ff] <= sbuf_data;
    end
  end

  // hand-back word: owner cleared, size fault flagged
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_valid_ff <= 1'b0;
      wb_word0_ff <= 32'h0000_0000;
      fault_ff    <= 1'b0;
    end else begin
      wb_valid_ff <= (state_ff == ST_DONE);
      if (state_ff == ST_DONE) begin
        wb_word0_ff              <= sd0_ff;
        wb_word0_ff[SD0_OWN_BIT] <= 1'b0;
        wb_word0_ff[SD0_SE_BIT]  <= ~size_ok;
        wb_word0_ff[SD0_ES_BIT]  <= ~size_ok;
        fault_ff                 <= ~size_ok;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive address filter
  // crc-32 over 48 address bits, nine top bits out
  function automatic logic [8:0] hash_index(input logic [47:0] a);
    logic [32:1] c;
    logic        m;
    c = '1;
    for (int j = 0; j < 48; j++) begin
      m = c[32] ^ a[j];
      // shift in the feedback bit, then fold it into the crc-32 taps
      c = {c[31:1], m} ^ ({32{m}} & 32'h04C1_1DB6);
    end
    return {c[24], c[25], c[26], c[27], c[28], c[29], c[30], c[31],
            c[32]};
  endfunction

  for (genvar g = 0; g < PERFECT_ENTRIES; g++) begin : g_cmp
    assign hit[g] = {tbl_ff[2*g+1][15:0], tbl_ff[2*g]} == rx_dest;
  end

  assign hidx      = hash_index(rx_dest);
  assign multicast = rx_dest[0];
  assign phys_hit  = {tbl_ff[PHYS_WORD_HI][15:0], tbl_ff[PHYS_WORD_LO]}
                   == rx_dest;
  // inverse only in exact mode without promisc/allmulti
  assign inv_eff   = inv_ff & ~hash_ff & ~mode_ff[MODE_PROMISC_BIT]
                   & ~mode_ff[MODE_ALLMULTI_BIT];

  always_comb begin
    nxt_accept = 1'b0;
    if (mode_ff[MODE_PROMISC_BIT]) begin
      nxt_accept = 1'b1;
    end else if (multicast && mode_ff[MODE_ALLMULTI_BIT]) begin
      nxt_accept = 1'b1;
    end else if (hash_ff) begin
      nxt_accept = multicast ? tbl_ff[hidx[8:5]][hidx[4:0]] : phys_hit;
    end else begin
      nxt_accept = inv_eff ? ~(|hit) : (|hit);
    end
  end

  // frames arriving while detached are not taken in
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_result_valid_ff <= 1'b0;
      rx_accept_ff       <= 1'b0;
    end else begin
      rx_result_valid_ff <= rx_dest_valid & ~rx_detach_ff;
      rx_accept_ff       <= nxt_accept & rx_dest_valid & ~rx_detach_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chain_addr_kind_a: assert property (
    txd_valid && tx_desc_word1[TD1_CA_BIT]
    |=> txd_kind_ff == ADDR_NEXT_DSC)
    else $error("chained descriptor not decoded as next descriptor");
  addr_passthru_a: assert property (
    txd_valid |=> txd_addr_ff == $past(tx_buffer_address_word))
    else $error("buffer address altered");
  watchdog_mask_a: assert property (
    tx_cause == CAUSE_WATCHDOG |=> status_valid_ff == 7'b0100011)
    else $error("watchdog validity mask wrong");
  detach_hold_a: assert property (
    state_ff == ST_FETCH |-> rx_detach_ff && !rx_result_valid_ff)
    else $error("receiver attached during setup load");
  prereq_wait_a: assert property (
    state_ff == ST_WAIT && (tx_prior_pending || rx_frame_busy)
    |=> state_ff == ST_WAIT)
    else $error("setup started before prior work drained");
  size_fault_a: assert property (
    state_ff == ST_WAIT && prereq_ok && !size_ok
    |=> ##1 wb_valid_ff && wb_word0_ff[SD0_SE_BIT]
            && wb_word0_ff[SD0_ES_BIT])
    else $error("size fault bits not reported");
  owner_clear_a: assert property (
    wb_valid_ff |-> !wb_word0_ff[SD0_OWN_BIT])
    else $error("descriptor handed back still owned");
  ic_sets_ti_a: assert property (
    state_ff == ST_DONE && sd1_ff[SD1_IC_BIT] |=> ti_ff)
    else $error("transmit interrupt flag not set");
  table_keep_a: assert property (
    state_ff == ST_WAIT && prereq_ok && !size_ok
    |=> $stable(tbl_ff[0]) && state_ff == ST_DONE)
    else $error("table touched by bad setup frame");
  promisc_accept_a: assert property (
    rx_dest_valid && !rx_detach_ff && mode_ff[MODE_PROMISC_BIT]
    |=> rx_accept_ff)
    else $error("frame refused in promiscuous mode");

endmodule
`default_nettype wire

/* File: tb/setup_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module setup_host_model
  import setup_filter_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // frame request from the bench
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic        hash,
  input  wire logic        inv,
  input  wire logic        ic,
  input  wire logic [14:0] bs,
  input  wire logic [31:0] buf_words [32],
  // descriptor side
  input  wire logic        sd_ready,
  output logic             sd_valid_ff,
  output logic      [31:0] w0_ff,
  output logic      [31:0] w1_ff,
  output logic      [31:0] w2_ff,
  // buffer side
  input  wire logic        sbuf_ready,
  output logic             sbuf_valid_ff,
  output logic      [31:0] sbuf_data_ff
);
  logic [5:0] idx_ff;
  logic       load_ff;
  ////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sd_valid_ff <= 1'b0;
      load_ff     <= 1'b0;
      w0_ff       <= 32'h0000_0000;
      w1_ff       <= 32'h0000_0000;
      w2_ff       <= 32'h0000_0000;
    end else if (go) begin
      sd_valid_ff <= 1'b1;
      w0_ff       <= 32'h8000_0000;
      w1_ff       <= {2'h0, DT_SETUP, 1'b0, inv, hash, ic, 24'h000000};
      w2_ff       <= {1'b0, bs, 16'h0000};
    end else if (sd_valid_ff && sd_ready) begin
      // released words must not keep showing the last value
      sd_valid_ff <= 1'b0;
      w0_ff       <= ~w0_ff;
      w1_ff       <= ~w1_ff;
      w2_ff       <= ~w2_ff;
      load_ff     <= (bs == SETUP_BYTES);
    end else if (sbuf_valid_ff && sbuf_ready && idx_ff == 6'h20) begin
      load_ff     <= 1'b0;
    end
  end
  ////////////////////////////////////////
  // whole frame from one word-aligned buffer, word by word
  always_ff @(posedge clk) begin
    if (!rst_b || !load_ff) begin
      sbuf_valid_ff <= 1'b0;
      idx_ff        <= 6'h00;
      sbuf_data_ff  <= rst_b ? ~sbuf_data_ff : 32'h0F0F_0F0F;
    end else if (!sbuf_valid_ff || sbuf_ready) begin
      if (idx_ff < 6'h20 && !(slow && sbuf_valid_ff)) begin
        sbuf_valid_ff <= 1'b1;
        sbuf_data_ff  <= buf_words[idx_ff[4:0]];
        idx_ff        <= idx_ff + 6'h01;
      end else begin
        sbuf_valid_ff <= 1'b0;
        sbuf_data_ff  <= ~sbuf_data_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/setup_frame_filter_loader_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module setup_frame_filter_loader_tb_top;
  import setup_filter_pkg::*;
  typedef struct packed {
    logic [31:0] w1;
    logic [31:0] a;
    tx_cause_t   c;
    addr_kind_t  k;
    logic [6:0]  v;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        txd_valid = 1'b0;
  logic [31:0] tx_desc_word1 = 32'h0000_0000;
  logic [31:0] tx_buffer_address_word = 32'h0000_0000;
  logic        txd_out_valid_ff;
  addr_kind_t  txd_kind_ff;
  logic [31:0] txd_addr_ff;
  tx_cause_t   tx_cause = CAUSE_NORMAL;
  logic [6:0]  status_valid_ff;
  logic        tx_running = 1'b0;
  logic        tx_prior_pending = 1'b1;
  logic        rx_frame_busy = 1'b1;
  logic        sd_valid;
  logic        sd_ready;
  logic [31:0] setup_desc_word0;
  logic [31:0] setup_desc_word1;
  logic [31:0] setup_desc_word2;
  logic        sbuf_valid;
  logic        sbuf_ready;
  logic [31:0] sbuf_data;
  logic        wb_valid_ff;
  logic [31:0] wb_word0_ff;
  logic        rx_detach_ff;
  logic        rx_dest_valid = 1'b0;
  logic [47:0] rx_dest = 48'h0000_0000_0000;
  logic        rx_result_valid_ff;
  logic        rx_accept_ff;
  logic        go = 1'b0;
  logic        slow = 1'b0;
  logic        hash = 1'b0;
  logic        inv = 1'b0;
  logic        ic = 1'b0;
  logic [14:0] bs = 15'h0080;
  logic [31:0] sbuf_tab [32];
  logic [31:0] q;
  logic [8:0]  h;
  int          err_count = 0;
  int          total_checks = 0;
  row_t        rows [5] = '{
    '{32'h0000_0000, 32'h0001_2345, CAUSE_NORMAL, ADDR_BUFFER, 7'h7F},
    '{32'h4080_0000, 32'h8000_1000, CAUSE_UNDERFLOW, ADDR_SV_PTE, 7'h1B},
    '{32'h4000_0000, 32'h0000_2004, CAUSE_EXCESS, ADDR_PA_PTE, 7'h7D},
    '{32'h4180_0000, 32'h0000_3000, CAUSE_WATCHDOG, ADDR_NEXT_DSC, 7'h23},
    '{32'h0100_0000, 32'hFFFF_FFFF, CAUSE_LOOPBACK, ADDR_NEXT_DSC, 7'h1B}
  };
  always #50 clk = ~clk;
  setup_frame_filter_loader setup_frame_filter_loader_i (
    .clk, .rst_b, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .txd_valid, .tx_desc_word1, .tx_buffer_address_word,
    .txd_out_valid_ff, .txd_kind_ff, .txd_addr_ff, .tx_cause,
    .status_valid_ff, .tx_running, .tx_prior_pending, .rx_frame_busy,
    .sd_valid, .sd_ready, .setup_desc_word0, .setup_desc_word1,
    .setup_desc_word2, .sbuf_valid, .sbuf_ready, .sbuf_data,
    .wb_valid_ff, .wb_word0_ff, .rx_detach_ff, .rx_dest_valid, .rx_dest,
    .rx_result_valid_ff, .rx_accept_ff
  );
  setup_host_model setup_host_model_i (
    .clk, .rst_b, .go, .slow, .hash, .inv, .ic, .bs,
    .buf_words(sbuf_tab), .sd_ready, .sd_valid_ff(sd_valid),
    .w0_ff(setup_desc_word0), .w1_ff(setup_desc_word1),
    .w2_ff(setup_desc_word2), .sbuf_ready, .sbuf_valid_ff(sbuf_valid),
    .sbuf_data_ff(sbuf_data)
  );
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // waitrequest and read data are both taken at the rising edge
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin err_count++; stop_test(); end
  endtask
  task automatic rx(input logic [47:0] a, input logic e);
    @(posedge clk);
    rx_dest_valid <= 1'b1;
    rx_dest <= a;
    @(posedge clk);
    rx_dest_valid <= 1'b0;
    @(negedge clk);
    chk(32'(rx_result_valid_ff), 32'h1);
    chk(32'(rx_accept_ff), 32'(e));
  endtask
  task automatic setup(input logic hp, fi, c, s, input logic [14:0] n);
    @(posedge clk);
    hash <= hp;
    inv <= fi;
    ic <= c;
    slow <= s;
    bs <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic wait_wb();
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (wb_valid_ff === 1'b1) break;
    end
    if (k == 300) begin err_count++; stop_test(); end
  endtask
  function automatic logic [8:0] hash9(input logic [47:0] a);
    logic [31:0] c;
    logic        m;
    logic [8:0]  r;
    c = 32'hFFFF_FFFF;
    for (int j = 0; j < 48; j++) begin
      m = c[31] ^ a[j];
      c = {c[30:0], m} ^ ({32{m}} & 32'h04C1_1DB6);
    end
    for (int k = 0; k < 9; k++) begin
      r[8-k] = c[23+k];
    end
    return r;
  endfunction
  ////////////////////////////////////////
  initial begin
    sbuf_tab = '{default: 32'h0000_0000};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      @(posedge clk);
      txd_valid <= 1'b1;
      tx_desc_word1 <= rows[r].w1;
      tx_buffer_address_word <= rows[r].a;
      tx_cause <= rows[r].c;
      @(posedge clk);
      txd_valid <= 1'b0;
      @(negedge clk);
      chk(32'(txd_out_valid_ff), 32'h1);
      chk(32'(txd_kind_ff), 32'(rows[r].k));
      chk(txd_addr_ff, rows[r].a);
      chk(32'(status_valid_ff), 32'(rows[r].v));
    end
    bus(1'b0, MODE_REG_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b0, STATUS_REG_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h08, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    rx(48'h0000_0000_0000, 1'b1);
    rx(48'h0000_0000_0200, 1'b0);
    for (int i = 0; i < 16; i++) begin
      sbuf_tab[2*i] = 32'h3300_0010 + i;
      sbuf_tab[2*i+1] = 32'h5A5A_0100 + i;
    end
    // setup queued before the filter is relied on
    // loading is held off by each gate in turn
    setup(1'b0, 1'b0, 1'b1, 1'b1, 15'h0080);
    repeat (4) @(negedge clk);
    chk(32'(rx_detach_ff), 32'h1);
    chk(32'(sbuf_ready), 32'h0);
    @(posedge clk);
    rx_dest_valid <= 1'b1;
    @(posedge clk);
    rx_dest_valid <= 1'b0;
    @(negedge clk);
    chk(32'(rx_result_valid_ff), 32'h0);
    @(posedge clk);
    tx_running <= 1'b1;
    repeat (4) @(negedge clk);
    chk(32'(sbuf_ready), 32'h0);
    @(posedge clk);
    tx_prior_pending <= 1'b0;
    repeat (4) @(negedge clk);
    chk(32'(sbuf_ready), 32'h0);
    @(posedge clk);
    rx_frame_busy <= 1'b0;
    wait_wb();
    chk(wb_word0_ff, 32'h0000_0000);
    bus(1'b0, STATUS_REG_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    rx(48'h0100_3300_0010, 1'b1);
    rx(48'h010F_3300_001F, 1'b1);
    rx(48'h0100_3300_0011, 1'b0);
    bus(1'b1, STATUS_REG_OFS, 32'h0000_0001, q);
    setup(1'b0, 1'b1, 1'b0, 1'b0, 15'h0080);
    wait_wb();
    bus(1'b0, STATUS_REG_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0008);
    rx(48'h0100_3300_0010, 1'b0);
    rx(48'h0100_3300_0011, 1'b1);
    bus(1'b1, MODE_REG_OFS, 32'h0000_0001, q);
    rx(48'h0100_3300_0010, 1'b1);
    bus(1'b1, MODE_REG_OFS, 32'h0000_0002, q);
    rx(48'h0100_3300_0010, 1'b1);
    bus(1'b1, MODE_REG_OFS, 32'h0000_0000, q);
    sbuf_tab = '{default: 32'h0000_0000};
    h = hash9(48'h0027_0025_0025);
    sbuf_tab[h[8:5]][h[4:0]] = 1'b1;
    sbuf_tab[16] = 32'h3534_12A8;
    sbuf_tab[17] = 32'h0000_0876;
    setup(1'b1, 1'b0, 1'b1, 1'b0, 15'h0080);
    wait_wb();
    bus(1'b0, STATUS_REG_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0005);
    rx(48'h0027_0025_0025, 1'b1);
    h = hash9(48'h0027_0025_0027);
    rx(48'h0027_0025_0027, sbuf_tab[h[8:5]][h[4:0]]);
    rx(48'h0876_3534_12A8, 1'b1);
    rx(48'h0876_3534_12AA, 1'b0);
    bus(1'b1, STATUS_REG_OFS, 32'h0000_0001, q);
    setup(1'b1, 1'b0, 1'b0, 1'b0, 15'h0040);
    wait_wb();
    chk(wb_word0_ff, 32'h0000_A000);
    bus(1'b0, STATUS_REG_OFS, 32'h0000_0000, q);
    chk(q & 32'h0000_0011, 32'h0000_0010);
    rx(48'h0027_0025_0025, 1'b1);
    rx(48'h0876_3534_12A8, 1'b1);
    // mid-run reset empties the table and drops the mode flags
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, STATUS_REG_OFS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    rx(48'h0000_0000_0000, 1'b1);
    rx(48'h0876_3534_12A8, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
